// File: bench/adc_model.sv
// Converter model that answers each conversion request after a set delay
`timescale 1ns/1ps
`default_nettype none

module adc_model
    import prox_gesture_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       adc_start,
    input  wire logic       emitter_one,
    input  wire logic       emitter_two,
    input  wire logic       emitter_three,
    input  wire logic [7:0] dly,
    input  wire word_t      val_one,
    input  wire word_t      val_two,
    input  wire word_t      val_three,
    output logic            adc_done,
    output word_t           adc_value
);
    logic [7:0] cnt = 8'h00;
    logic [2:0] lit = 3'h0;

    initial adc_done = 1'b0;
    initial adc_value = 16'h0000;

    always @(posedge clk) begin
        adc_done <= 1'b0;
        // Outside its strobe the value bus toggles so no stale value looks valid
        adc_value <= ~adc_value;
        if (adc_start) begin
            cnt <= dly;
            lit <= {emitter_three, emitter_two, emitter_one};
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
            if (cnt == 8'h01) begin
                adc_done <= 1'b1;
                adc_value <= lit[0] ? val_one : (lit[1] ? val_two : val_three);
            end
        end
    end
endmodule

`default_nettype wire

// File: bench/proximity_gesture_sequencer_tb.sv
// Self-checking bench for the proximity gesture sequencer
`timescale 1ns/1ps
`default_nettype none
`include "prox_gesture_params.svh"

module proximity_gesture_sequencer_tb;
    import prox_gesture_pkg::*;

    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       ce = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    word_t      reg_wdata = 16'h0000;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] dly = 8'h14;
    word_t      val = 16'h0000;
    word_t      rd;
    wire word_t reg_rdata;
    wire word_t adc_value;
    wire logic  int_n;
    wire logic  e1;
    wire logic  e2;
    wire logic  e3;
    wire logic  adc_start;
    wire logic  adc_done;
    int         err_count = 0;
    int         total_checks = 0;
    int         n_start = 0;
    logic [2:0] order [0:3];

    always #25 clk = ~clk;

    proximity_gesture_sequencer dut (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .int_n(int_n), .emitter_one(e1),
        .emitter_two(e2), .emitter_three(e3), .adc_start(adc_start),
        .adc_done(adc_done), .adc_value(adc_value)
    );

    adc_model adc (
        .clk(clk), .adc_start(adc_start), .emitter_one(e1), .emitter_two(e2),
        .emitter_three(e3), .dly(dly), .val_one(val), .val_two(val + 16'h0111),
        .val_three(val + 16'h0222), .adc_done(adc_done), .adc_value(adc_value)
    );

    always @(posedge clk) begin
        if (adc_start === 1'b1 && n_start < 4) begin
            order[n_start] <= {e3, e2, e1};
            n_start <= n_start + 1;
        end
    end

    task automatic check(input string what, input word_t exp, input word_t got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input word_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        rd = reg_rdata;
    endtask

    task automatic wait_dones(input int n);
        int seen;
        seen = 0;
        for (int i = 0; i < 3000 && seen < n; i++) begin
            @(posedge clk);
            #1;
            if (adc_done === 1'b1) seen++;
        end
        if (seen < n) check("conversion count", 16'(n), 16'(seen));
        @(posedge clk);
        #1;
    endtask

    task automatic test_reset_map();
        reg_read(`ADDR_CONF);
        check("conf reset", `CONF_RESET, rd);
        reg_read(`ADDR_UPPER);
        check("upper reset", `UPPER_RESET, rd);
        reg_read(`ADDR_LOWER);
        check("lower reset", `LOWER_RESET, rd);
        reg_write(`ADDR_RESULT1, 16'h1234);
        reg_read(`ADDR_RESULT1);
        check("result1 read only", 16'h0000, rd);
        reg_read(8'h20);
        check("unmapped read", 16'h0000, rd);
        check("int_n idle", 16'h0001, {15'h0, int_n});
    endtask

    task automatic test_hysteresis();
        dly <= 8'h14;
        val <= 16'h0067;
        reg_write(`ADDR_UPPER, 16'h0064);
        reg_write(`ADDR_LOWER, 16'h0032);
        reg_write(`ADDR_CONF, 16'h00a1);
        wait_dones(2);
        check("int_n near", 16'h0000, {15'h0, int_n});
        check("lit emitter", 16'h0002, {13'h0, order[0]});
        reg_read(`ADDR_RESULT2);
        check("channel two result", 16'h0178, rd);
        reg_read(`ADDR_RESULT1);
        check("channel one idle", 16'h0000, rd);
        reg_read(`ADDR_FLAGS);
        check("near flag", 16'h0001, rd);
        check("int_n released", 16'h0001, {15'h0, int_n});
        val <= 16'hff35;
        wait_dones(2);
        reg_read(`ADDR_FLAGS);
        check("band flags", 16'h0000, rd);
        check("band int_n", 16'h0001, {15'h0, int_n});
        val <= 16'hff03;
        wait_dones(2);
        check("away int_n", 16'h0000, {15'h0, int_n});
        reg_read(`ADDR_FLAGS);
        check("away flag", 16'h0002, rd);
        // Logic output mode: the pin follows the near state
        val <= 16'h0067;
        reg_write(`ADDR_CONF, 16'h00b1);
        wait_dones(2);
        check("logic out near", 16'h0000, {15'h0, int_n});
        reg_read(`ADDR_STATUS);
        check("status near", 16'h0005, rd & 16'h0007);
        reg_read(`ADDR_FLAGS);
        check("logic mode flag", 16'h0001, rd);
        reg_write(`ADDR_CONF, 16'h0000);
        repeat (400) @(posedge clk);
    endtask

    task automatic test_gesture(input word_t conf, input logic exp_int);
        int dones;
        dly <= conf[1] ? 8'h01 : 8'h09;
        val <= 16'h0100;
        reg_write(`ADDR_CONF, conf);
        n_start = 0;
        repeat (300) @(posedge clk);
        #1;
        check("no start untriggered", 16'h0000, 16'(n_start));
        reg_write(`ADDR_TRIG, 16'h0001);
        repeat (2) @(posedge clk);
        #1;
        check("start after trigger", 16'h0001, 16'(n_start));
        dones = 0;
        for (int i = 0; i < 3000 && dones < 3; i++) begin
            if (int_n === 1'b0) check("early int_n", 16'h0001, 16'h0000);
            if (adc_done === 1'b1) dones++;
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        check("run dones", 16'h0003, 16'(dones));
        check("int_n done", {15'h0, exp_int}, {15'h0, int_n});
        for (int k = 0; k < 3; k++) begin
            check("emitter order", 16'(1 << k), {13'h0, order[k]});
            reg_read(`ADDR_RESULT1 + 8'(k));
            check("gesture result", 16'h0100 + 16'(k) * 16'h0111, rd);
        end
        check("single run", 16'h0003, 16'(n_start));
        reg_read(`ADDR_FLAGS);
        check("gesture ready", 16'h0004, rd);
        check("int_n cleared", 16'h0001, {15'h0, int_n});
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #(50 * 20000);
        err_count++;
        final_report();
    end

    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        test_reset_map();
        test_hysteresis();
        test_gesture(16'h008e, 1'b0);
        test_gesture(16'h008c, 1'b1);
        final_report();
    end
endmodule

`default_nettype wire

// File: src/emitter_sequencer.sv
// Emitter switching and converter handshake for one or three channels
`timescale 1ns/1ps
`default_nettype none

module emitter_sequencer
    import prox_gesture_pkg::*;
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic ce,
    meas_if.seq       mi,
    output logic      emitter_one,
    output logic      emitter_two,
    output logic      emitter_three,
    output logic      adc_start,
    input  wire logic adc_done,
    input  wire word_t adc_value
);

    seq_regs_t r;
    seq_regs_t next_r;

    always_comb begin
        next_r = r;
        next_r.res_valid = 1'b0;
        next_r.done = 1'b0;
        case (r.state)
            SEQ_IDLE: begin
                if (mi.start) begin
                    next_r.gesture = mi.gesture;
                    next_r.chan = mi.gesture ? 2'h0 : mi.sel;
                    next_r.state = SEQ_FIRE;
                end
            end
            SEQ_FIRE: begin
                next_r.state = SEQ_WAIT;
            end
            SEQ_WAIT: begin
                if (adc_done) begin
                    next_r.res_valid = 1'b1;
                    next_r.res_chan = r.chan;
                    next_r.res_value = adc_value;
                    if (r.gesture && r.chan != 2'h2) begin
                        // Gesture run steps one, two, three in turn
                        next_r.chan = 2'(r.chan + 2'h1); // R7
                        next_r.state = SEQ_FIRE;
                    end else begin
                        next_r.done = 1'b1;
                        next_r.state = SEQ_IDLE;
                    end
                end
            end
            default: begin
                next_r.state = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign mi.busy      = (r.state != SEQ_IDLE);
    assign mi.res_valid = r.res_valid;
    assign mi.res_chan  = r.res_chan;
    assign mi.res_value = r.res_value;
    assign mi.seq_done  = r.done;
    assign adc_start    = (r.state == SEQ_FIRE);
    // Only the emitter of the current channel is lit
    assign emitter_one   = mi.busy && (r.chan == 2'h0); // R4
    assign emitter_two   = mi.busy && (r.chan == 2'h1); // R4
    assign emitter_three = mi.busy && (r.chan == 2'h2); // R4

    sequence first_result;
        ce && r.res_valid && r.gesture && (r.res_chan == 2'h0);
    endsequence

    sequence second_result;
        ce && r.res_valid && r.gesture && (r.res_chan == 2'h1);
    endsequence

    sequence gesture_launch;
        ce && !mi.busy && mi.start && mi.gesture;
    endsequence

    one_emitter_a: assert property (@(posedge clk) disable iff (sys_rst) // R4
        $onehot0({emitter_three, emitter_two, emitter_one}))
        else $error("more than one emitter lit");

    order_first_a: assert property (@(posedge clk) disable iff (sys_rst) // R7
        gesture_launch |=> emitter_one && adc_start)
        else $error("gesture run did not begin on emitter one");

    order_next_a: assert property (@(posedge clk) disable iff (sys_rst) // R7
        first_result |-> emitter_two && adc_start)
        else $error("emitter two did not follow emitter one");

    order_last_a: assert property (@(posedge clk) disable iff (sys_rst) // R7
        second_result |-> emitter_three && adc_start)
        else $error("emitter three did not follow emitter two");

endmodule

`default_nettype wire

// File: src/meas_if.sv
// Measurement request and result link between control and emitter sequencer
`timescale 1ns/1ps
`default_nettype none

interface meas_if;
    import prox_gesture_pkg::*;

    logic  start;
    logic  gesture;
    chan_t sel;
    logic  busy;
    logic  res_valid;
    chan_t res_chan;
    word_t res_value;
    logic  seq_done;

    modport ctrl (
        output start,
        output gesture,
        output sel,
        input  busy,
        input  res_valid,
        input  res_chan,
        input  res_value,
        input  seq_done
    );

    modport seq (
        input  start,
        input  gesture,
        input  sel,
        output busy,
        output res_valid,
        output res_chan,
        output res_value,
        output seq_done
    );

endinterface

`default_nettype wire

// File: src/prox_gesture_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PROX_GESTURE_PARAMS_SVH
`define PROX_GESTURE_PARAMS_SVH

`define ADDR_CONF          8'h00
`define ADDR_TRIG          8'h01
`define ADDR_UPPER         8'h02
`define ADDR_LOWER         8'h03
`define ADDR_RESULT1       8'h04
`define ADDR_RESULT2       8'h05
`define ADDR_RESULT3       8'h06
`define ADDR_FLAGS         8'h07
`define ADDR_STATUS        8'h08

`define CONF_PROX_INT_EN   0
`define CONF_GEST_INT_EN   1
`define CONF_GESTURE_MODE  2
`define CONF_SINGLE_SHOT   3
`define CONF_LOGIC_OUT     4
`define CONF_SEL_LSB       5
`define CONF_SEL_MSB       6
`define CONF_PROX_EN       7
`define CONF_MASK          16'h00ff

`define TRIG_BIT           0

`define FLAG_CLOSE         0
`define FLAG_AWAY          1
`define FLAG_GESTURE       2

`define STATUS_CHAN_LSB    0
`define STATUS_CHAN_MSB    1
`define STATUS_NEAR        2
`define STATUS_BUSY        3

`define CONF_RESET         16'h0000
`define UPPER_RESET        16'hffff
`define LOWER_RESET        16'h0000

`define CLK_PERIOD_NS      50
`define MEAS_GAP_NS        10000
`define MEAS_GAP_CYCLES    ((`MEAS_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: src/prox_gesture_pkg.sv
// Types shared by the proximity gesture sequencer modules
package prox_gesture_pkg;

    typedef logic [15:0] word_t;
    typedef logic [1:0]  chan_t;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_FIRE = 2'b01,
        SEQ_WAIT = 2'b10
    } seq_state_t;

    typedef struct packed {
        seq_state_t state;
        chan_t      chan;
        logic       gesture;
        logic       res_valid;
        chan_t      res_chan;
        word_t      res_value;
        logic       done;
    } seq_regs_t;

    typedef struct packed {
        word_t       conf;
        word_t       upper;
        word_t       lower;
        word_t [2:0] result;
        logic [2:0]  flags;
        logic        near;
        logic [7:0]  gap;
        logic        gesture_run;
        word_t       rdata;
        logic        int_n;
    } ctrl_regs_t;

endpackage

// File: src/proximity_gesture_sequencer.sv
// Proximity hysteresis, interrupt flags and gesture sequencing control
//
// Functional notes
// R1: A near interrupt is raised when a result rises above the upper threshold.
// R2: Results inside the band between the thresholds never change the near state.
// R3: The host clears the interrupt and holds its state until results fall below the lower one.
// R4: Up to three emitters are driven and any single one can be chosen for plain measuring.
// R5: A result from an emitter lands in the result register of that emitter's channel.
// R6: The host sets the gesture mode bit to use all three emitters. The code also needs the single-shot bit set for a gesture run.
// R7: A single-shot gesture run lights emitters one, two and three in turn, each to its register.
// R8: With gesture and single-shot both set, a trigger write starts the run at once.
// R9: The end of the run sets the gesture ready flag and, if enabled, pulls the interrupt low.
// R10: The interrupt pin goes low whenever an enabled flag becomes set. In logic output mode the code drives the pin from the near state instead.
// R11: Reading the flag register clears the flags and returns the pin high. In logic output mode the pin stays low while the near state is set.
// R12: In single-shot mode nothing is measured without a trigger and the block stays idle.
// R13: The gesture ready flag rises only once the third result has been stored.
`timescale 1ns/1ps
`default_nettype none
`include "prox_gesture_params.svh"

module proximity_gesture_sequencer
    import prox_gesture_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       ce,
    input  wire logic [7:0] reg_addr,
    input  wire word_t      reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output word_t           reg_rdata,
    output logic            int_n,
    output logic            emitter_one,
    output logic            emitter_two,
    output logic            emitter_three,
    output logic            adc_start,
    input  wire logic       adc_done,
    input  wire word_t      adc_value
);

    ctrl_regs_t  r;
    ctrl_regs_t  next_r;
    logic [2:0]  flag_set;
    logic [2:0]  flag_clr;
    logic [2:0]  flag_mask;
    logic        trig_wr;
    logic        single_shot;
    logic        gesture_mode;
    logic        logic_out;
    chan_t       sel;

    meas_if mi ();

    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
        reg_hit = (addr == offset);
    endfunction

    // Channel code 3 has no emitter, so it falls back to emitter one
    function automatic chan_t clamp_chan(input chan_t c);
        clamp_chan = (c == 2'h3) ? 2'h0 : c;
    endfunction

    function automatic logic [2:0] int_mask(input word_t conf);
        int_mask = {conf[`CONF_GEST_INT_EN], conf[`CONF_PROX_INT_EN], conf[`CONF_PROX_INT_EN]};
    endfunction

    function automatic ctrl_regs_t reset_value();
        ctrl_regs_t v;
        v = '0;
        v.conf = `CONF_RESET;
        v.upper = `UPPER_RESET;
        v.lower = `LOWER_RESET;
        v.int_n = 1'b1;
        reset_value = v;
    endfunction

    assign single_shot  = r.conf[`CONF_SINGLE_SHOT];
    assign gesture_mode = r.conf[`CONF_GESTURE_MODE];
    assign logic_out    = r.conf[`CONF_LOGIC_OUT];
    assign sel          = clamp_chan(r.conf[`CONF_SEL_MSB:`CONF_SEL_LSB]); // R4
    assign trig_wr      = reg_wr && reg_hit(reg_addr, `ADDR_TRIG) && reg_wdata[`TRIG_BIT];
    assign flag_mask    = int_mask(r.conf);

    // Three emitters are used only when the host has chosen gesture mode
    assign mi.gesture = gesture_mode && single_shot; // R6
    assign mi.sel     = sel;
    // Single-shot waits for a trigger; free running waits out the gap
    assign mi.start   = ce && !mi.busy &&
                        (single_shot ? trig_wr                                // R8 R12
                                     : (r.conf[`CONF_PROX_EN] && r.gap == 8'h00));

    always_comb begin
        next_r = r;
        next_r.rdata = '0;
        flag_set = '0;
        flag_clr = '0;

        if (reg_wr) begin
            if (reg_hit(reg_addr, `ADDR_CONF)) begin
                next_r.conf = reg_wdata & `CONF_MASK;
            end
            if (reg_hit(reg_addr, `ADDR_UPPER)) begin
                next_r.upper = reg_wdata;
            end
            if (reg_hit(reg_addr, `ADDR_LOWER)) begin
                next_r.lower = reg_wdata;
            end
        end

        if (reg_rd) begin
            case (reg_addr)
                `ADDR_CONF:    next_r.rdata = r.conf;
                `ADDR_UPPER:   next_r.rdata = r.upper;
                `ADDR_LOWER:   next_r.rdata = r.lower;
                `ADDR_RESULT1: next_r.rdata = r.result[0];
                `ADDR_RESULT2: next_r.rdata = r.result[1];
                `ADDR_RESULT3: next_r.rdata = r.result[2];
                `ADDR_FLAGS: begin
                    next_r.rdata = {13'h0000, r.flags};
                    flag_clr = 3'h7; // R11
                end
                `ADDR_STATUS: begin
                    next_r.rdata[`STATUS_CHAN_MSB:`STATUS_CHAN_LSB] = sel;
                    next_r.rdata[`STATUS_NEAR] = r.near;
                    next_r.rdata[`STATUS_BUSY] = mi.busy;
                end
                default: next_r.rdata = '0;
            endcase
        end

        if (mi.res_valid) begin
            next_r.result[mi.res_chan] = mi.res_value; // R5 R7
            if (!r.gesture_run) begin
                if (!r.near && mi.res_value > r.upper) begin
                    next_r.near = 1'b1; // R1
                    flag_set[`FLAG_CLOSE] = r.conf[`CONF_PROX_INT_EN]; // R1
                end else if (r.near && mi.res_value < r.lower) begin // R2
                    next_r.near = 1'b0;
                    flag_set[`FLAG_AWAY] = r.conf[`CONF_PROX_INT_EN];
                end
                // Inside the band the near state is simply held
            end
        end

        // Done coincides with the third result, stored at the same edge
        if (mi.seq_done && r.gesture_run) begin
            flag_set[`FLAG_GESTURE] = 1'b1; // R9 R13
        end

        // A new event wins over a clear in the same cycle
        next_r.flags = (r.flags & ~flag_clr) | flag_set; // R11

        if (mi.seq_done) begin
            next_r.gap = 8'(`MEAS_GAP_CYCLES - 1);
        end else if (r.gap != 8'h00) begin
            next_r.gap = 8'(r.gap - 8'h01);
        end

        if (mi.start) begin
            next_r.gesture_run = mi.gesture;
        end

        // Logic output mode shows the near state; otherwise any enabled flag
        if (next_r.conf[`CONF_LOGIC_OUT]) begin
            next_r.int_n = !next_r.near;
        end else begin
            next_r.int_n = !(|(next_r.flags & int_mask(next_r.conf))); // R9 R10 R11
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r <= reset_value();
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign reg_rdata = r.rdata;
    assign int_n     = r.int_n;

    emitter_sequencer u_seq (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .ce            (ce),
        .mi            (mi.seq),
        .emitter_one   (emitter_one),
        .emitter_two   (emitter_two),
        .emitter_three (emitter_three),
        .adc_start     (adc_start),
        .adc_done      (adc_done),
        .adc_value     (adc_value)
    );

    sequence crossing_up;
        ce && mi.res_valid && !r.gesture_run && !r.near && (mi.res_value > r.upper);
    endsequence

    sequence inside_band;
        ce && mi.res_valid && !r.gesture_run &&
        (mi.res_value <= r.upper) && (mi.res_value >= r.lower);
    endsequence

    sequence gesture_trigger;
        ce && trig_wr && single_shot && gesture_mode && !mi.busy;
    endsequence

    sequence flag_read_quiet;
        ce && reg_rd && reg_hit(reg_addr, `ADDR_FLAGS) && !mi.res_valid && !mi.seq_done;
    endsequence

    near_rise_a: assert property (@(posedge clk) disable iff (sys_rst) // R1
        crossing_up ##0 r.conf[`CONF_PROX_INT_EN] |=> r.near && r.flags[`FLAG_CLOSE])
        else $error("crossing above upper threshold raised no near flag");

    band_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // R2
        inside_band |=> (r.near == $past(r.near)) && !$rose(r.flags[`FLAG_CLOSE]))
        else $error("near state changed inside the threshold band");

    chan_map_a: assert property (@(posedge clk) disable iff (sys_rst) // R5
        ce && mi.res_valid |=> r.result[$past(mi.res_chan)] == $past(mi.res_value))
        else $error("result not stored in its own channel");

    trig_start_a: assert property (@(posedge clk) disable iff (sys_rst) // R8
        gesture_trigger |=> mi.busy && r.gesture_run && adc_start)
        else $error("trigger did not start the gesture run");

    ready_flag_a: assert property (@(posedge clk) disable iff (sys_rst) // R13
        ce && $rose(r.flags[`FLAG_GESTURE]) |-> $past(mi.seq_done) && $past(r.gesture_run))
        else $error("gesture ready flag rose before the run ended");

    int_low_a: assert property (@(posedge clk) disable iff (sys_rst) // R10
        !logic_out && (|(r.flags & flag_mask)) |-> !int_n)
        else $error("enabled flag set but interrupt pin high");

    read_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // R11
        flag_read_quiet ##0 !r.conf[`CONF_LOGIC_OUT] ##0 !reg_wr
        |=> (r.flags == 3'h0) && int_n && (reg_rdata[2:0] == $past(r.flags)))
        else $error("flag read did not clear flags and release pin");

    standby_a: assert property (@(posedge clk) disable iff (sys_rst) // R12
        ce && single_shot && !mi.busy && !trig_wr |=> !mi.busy && !adc_start)
        else $error("single-shot mode measured without a trigger");

    sequence crossing_down;
        ce && mi.res_valid && !r.gesture_run && r.near && (mi.res_value < r.lower);
    endsequence

    sequence gesture_end;
        ce && mi.seq_done && r.gesture_run;
    endsequence

    near_release_a: assert property (@(posedge clk) disable iff (sys_rst) // R2
        crossing_down |=> !r.near)
        else $error("fall below lower threshold kept the near state");

    away_flag_a: assert property (@(posedge clk) disable iff (sys_rst) // R2
        crossing_down ##0 r.conf[`CONF_PROX_INT_EN] |=> r.flags[`FLAG_AWAY])
        else $error("fall below lower threshold raised no away flag");

    near_pin_a: assert property (@(posedge clk) disable iff (sys_rst) // R10
        crossing_up ##0 r.conf[`CONF_PROX_INT_EN] ##0 !logic_out ##0 !reg_wr |=> !int_n)
        else $error("near event did not pull the interrupt pin low");

    third_ready_a: assert property (@(posedge clk) disable iff (sys_rst) // R13
        gesture_end |-> mi.res_valid && (mi.res_chan == 2'h2))
        else $error("gesture run ended without the third result");

    ready_set_a: assert property (@(posedge clk) disable iff (sys_rst) // R9
        gesture_end |=> r.flags[`FLAG_GESTURE])
        else $error("gesture run ended without setting the ready flag");

    ready_pin_a: assert property (@(posedge clk) disable iff (sys_rst) // R9
        gesture_end ##0 r.conf[`CONF_GEST_INT_EN] ##0 !logic_out ##0 !reg_wr |=> !int_n)
        else $error("gesture ready did not pull the interrupt pin low");

    flag_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // R11
        ce && !(reg_rd && reg_hit(reg_addr, `ADDR_FLAGS))
        |=> ((r.flags & $past(r.flags)) == $past(r.flags)))
        else $error("flag cleared without a flag register read");

    pin_release_a: assert property (@(posedge clk) disable iff (sys_rst) // R11
        !logic_out && !(|(r.flags & flag_mask)) |-> int_n)
        else $error("interrupt pin low with no enabled flag set");

    logic_pin_a: assert property (@(posedge clk) disable iff (sys_rst) // R10
        logic_out |-> (int_n == !r.near))
        else $error("logic output pin does not follow the near state");

    result_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // R5
        ce && !mi.res_valid |=> (r.result == $past(r.result)))
        else $error("result register changed without a new result");

    plain_emitter_a: assert property (@(posedge clk) disable iff (sys_rst) // R4
        mi.start && !mi.gesture
        |=> ({emitter_three, emitter_two, emitter_one} == (3'h1 << $past(sel))))
        else $error("plain measurement lit the wrong emitter");

    trig_only_a: assert property (@(posedge clk) disable iff (sys_rst) // R12
        single_shot && !trig_wr |-> !mi.start)
        else $error("single-shot mode started without a trigger");

    idle_dark_a: assert property (@(posedge clk) disable iff (sys_rst) // R12
        !mi.busy |-> !adc_start && !emitter_one && !emitter_two && !emitter_three)
        else $error("emitter or converter active while idle");

endmodule

`default_nettype wire
